// [bcbt_regs.svh]
// Constants for the branch, call and bit-test execution block.
// Assumes it is included by bare name from the package and the modules.
`ifndef BCBT_REGS_SVH
`define BCBT_REGS_SVH

// ****************************************
// Widths
// ****************************************
`define BCBT_PC_W 15
`define BCBT_LIT_W 9
`define BCBT_CALL_W 11
`define BCBT_FADDR_W 7
`define BCBT_BITSEL_W 3
`define BCBT_DATA_W 8
`define BCBT_LATCH_W 7

// ****************************************
// Field positions and values
// ****************************************
`define BCBT_LATCH_HI 6
`define BCBT_LATCH_LO 3
`define BCBT_PC_RST 15'h0000
`define BCBT_PC_STEP 15'h0001
`define BCBT_PC_SKIP 15'h0002
`define BCBT_PC_MAX 15'h7fff

`endif

// [bcbt_pkg.sv]
// Types shared by the execution block and its testbench.
// Assumes bcbt_regs.svh is on the include path.
`default_nettype none
`include "bcbt_regs.svh"

package bcbt_pkg;

	// ****************************************
	// Operations carried out by this block
	// ****************************************
	typedef enum logic [2:0] {
		OP_BRANCH_RELATIVE_LITERAL = 3'h0,
		OP_BRANCH_RELATIVE_ACCUMULATOR = 3'h1,
		OP_SET_REGISTER_BIT = 3'h2,
		OP_TEST_SKIP_IF_CLEAR = 3'h3,
		OP_TEST_SKIP_IF_SET = 3'h4,
		OP_CALL_ABSOLUTE = 3'h5,
		OP_SPARE_6 = 3'h6,
		OP_SPARE_7 = 3'h7
	} bcbt_op_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_FINISH = 2'h2
	} bcbt_state_t;

	// One decoded request with its operands
	typedef struct packed {
		bcbt_op_t code;
		logic [`BCBT_LIT_W-1:0] literal;
		logic [`BCBT_CALL_W-1:0] target;
		logic [`BCBT_FADDR_W-1:0] faddr;
		logic [`BCBT_BITSEL_W-1:0] bitsel;
	} bcbt_req_t;

endpackage
`default_nettype wire

// [bcbt_bit_unit.sv]
// Bit select unit: sets or tests one bit of a data byte.
// Assumes data and select come from registered logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "bcbt_regs.svh"

module bcbt_bit_unit #(
	parameter int DATA_W = `BCBT_DATA_W,
	parameter int SEL_W = `BCBT_BITSEL_W
) (
	input wire logic [DATA_W-1:0] data_i,
	input wire logic [SEL_W-1:0] sel_i,
	output logic [DATA_W-1:0] set_o,
	output logic bit_o
);

	// ****************************************
	// One-hot mask, one entry per bit
	// ****************************************
	logic [DATA_W-1:0] mask; // Selected bit position

	generate
		if (DATA_W != (1 << SEL_W)) begin : g_bad
			$error("bcbt_bit_unit: DATA_W must equal 2**SEL_W");
		end
		for (genvar i = 0; i < DATA_W; i++) begin : g_mask
			assign mask[i] = (sel_i == SEL_W'(i));
		end
	endgenerate

	// Other bits pass through untouched
	assign set_o = data_i | mask;
	assign bit_o = |(data_i & mask);

endmodule
`default_nettype wire

// [bcbt_exec.sv]
// Execution sequencer for relative branches, bit set, bit test and skip,
// and the absolute subroutine call. Holds the program counter.
// Assumes requests, accumulator, upper latch and data memory read data
// come from logic on mclk_i; the data memory answers reads combinationally.
`timescale 1ns/1ns
`default_nettype none
`include "bcbt_regs.svh"

// Operation
// - Literal branch target is pc plus one plus signed offset
// - Literal branch: two cycles, flags untouched
// - Accumulator branch adds unsigned accumulator plus one
// - Accumulator branch: two cycles, flags untouched
// - Set bit forces one bit, others kept
// - Call pushes pc plus one in its second cycle, after the counter has moved
// - Call loads target and upper latch bits
// - Call: two cycles, flags untouched
module bcbt_exec (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic op_valid_i,
	input wire bcbt_pkg::bcbt_req_t op_i,
	input wire logic [`BCBT_DATA_W-1:0] accum_i,
	input wire logic [`BCBT_LATCH_W-1:0] pc_upper_latch_i,
	input wire logic [`BCBT_DATA_W-1:0] dm_rdata_i,
	output logic op_ready_o,
	output logic op_done_o,
	output logic [`BCBT_PC_W-1:0] pc_o,
	output logic [`BCBT_FADDR_W-1:0] dm_addr_o,
	output logic dm_we_o,
	output logic [`BCBT_DATA_W-1:0] dm_wdata_o,
	output logic return_stack_top_push_o,
	output logic [`BCBT_PC_W-1:0] return_stack_top_o,
	output logic discard_next_o,
	output logic status_we_o
);

	// ****************************************
	// State and snapshots
	// ****************************************
	bcbt_pkg::bcbt_state_t state_reg; // Sequencer state
	bcbt_pkg::bcbt_state_t state_next; // Its next value
	bcbt_pkg::bcbt_req_t op_reg; // Request held for execution
	logic [`BCBT_DATA_W-1:0] accum_reg; // Accumulator at acceptance
	logic [`BCBT_LATCH_W-1:0] latch_reg; // Upper latch at acceptance
	logic [`BCBT_PC_W-1:0] pc_reg; // Address of current instruction
	logic [`BCBT_PC_W-1:0] pc_next; // Counter after execution
	logic push_reg; // Return stack push strobe
	logic [`BCBT_PC_W-1:0] push_data_reg; // Return address
	logic discard_reg; // Next fetched word is dropped
	logic dm_we_reg; // Write-back strobe
	logic [`BCBT_DATA_W-1:0] dm_wdata_reg; // Write-back byte
	logic accept; // Request taken this cycle
	logic in_exec; // First execution cycle
	logic [`BCBT_DATA_W-1:0] set_val; // Byte with selected bit forced
	logic bit_val; // Selected bit as read
	logic skip; // Bit test asks for a skip
	logic two_cycle; // Operation needs a second cycle
	logic [`BCBT_PC_W-1:0] pc_inc; // Already incremented counter

	assign accept = op_ready_o && op_valid_i;
	assign in_exec = (state_reg == bcbt_pkg::ST_EXEC);
	assign pc_inc = pc_reg + `BCBT_PC_STEP;

	// ****************************************
	// Bit unit on the addressed register
	// ****************************************
	bcbt_bit_unit #(
		.DATA_W(`BCBT_DATA_W),
		.SEL_W(`BCBT_BITSEL_W)
	) u_bit (
		.data_i(dm_rdata_i),
		.sel_i(op_reg.bitsel),
		.set_o(set_val),
		.bit_o(bit_val)
	);

	// Skip decision; the two test forms differ only in polarity
	always_comb begin
		case (op_reg.code)
			bcbt_pkg::OP_TEST_SKIP_IF_CLEAR: skip = !bit_val;
			bcbt_pkg::OP_TEST_SKIP_IF_SET: skip = bit_val;
			default: skip = 1'b0;
		endcase
	end

	// Branches and call always need the second cycle; tests only on skip
	always_comb begin
		case (op_reg.code)
			bcbt_pkg::OP_BRANCH_RELATIVE_LITERAL: two_cycle = 1'b1;
			bcbt_pkg::OP_BRANCH_RELATIVE_ACCUMULATOR: two_cycle = 1'b1;
			bcbt_pkg::OP_CALL_ABSOLUTE: two_cycle = 1'b1;
			default: two_cycle = skip;
		endcase
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		case (state_reg)
			bcbt_pkg::ST_IDLE: begin
				state_next = accept ? bcbt_pkg::ST_EXEC : bcbt_pkg::ST_IDLE;
			end
			bcbt_pkg::ST_EXEC: begin
				state_next = two_cycle ? bcbt_pkg::ST_FINISH :
					bcbt_pkg::ST_IDLE;
			end
			bcbt_pkg::ST_FINISH: state_next = bcbt_pkg::ST_IDLE;
			default: state_next = bcbt_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= bcbt_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Snapshot operands so outside changes during execution do not leak in
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			op_reg <= '0;
			accum_reg <= '0;
			latch_reg <= '0;
		end else if (accept) begin
			op_reg <= op_i;
			accum_reg <= accum_i;
			latch_reg <= pc_upper_latch_i;
		end
	end

	// ****************************************
	// Program counter
	// ****************************************
	// Sums are cut to the counter width, so targets wrap around
	always_comb begin
		case (op_reg.code)
			bcbt_pkg::OP_BRANCH_RELATIVE_LITERAL: begin
				pc_next = `BCBT_PC_W'(pc_inc +
					`BCBT_PC_W'(signed'(op_reg.literal)));
			end
			bcbt_pkg::OP_BRANCH_RELATIVE_ACCUMULATOR: begin
				pc_next = `BCBT_PC_W'(pc_inc +
					`BCBT_PC_W'(accum_reg));
			end
			bcbt_pkg::OP_CALL_ABSOLUTE: begin
				pc_next = {latch_reg[`BCBT_LATCH_HI:`BCBT_LATCH_LO],
					op_reg.target};
			end
			bcbt_pkg::OP_TEST_SKIP_IF_CLEAR,
			bcbt_pkg::OP_TEST_SKIP_IF_SET: begin
				pc_next = skip ? pc_reg + `BCBT_PC_SKIP : pc_inc;
			end
			default: pc_next = pc_inc;
		endcase
	end

	// Counter moves once per instruction, at the end of the first cycle
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pc_reg <= `BCBT_PC_RST;
		end else if (in_exec) begin
			pc_reg <= pc_next;
		end
	end

	// ****************************************
	// Return stack push
	// ****************************************
	// Return address is taken from the counter before it is reloaded
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			push_reg <= 1'b0;
			push_data_reg <= '0;
		end else begin
			push_reg <= in_exec &&
				(op_reg.code == bcbt_pkg::OP_CALL_ABSOLUTE);
			if (in_exec) begin
				push_data_reg <= pc_inc;
			end
		end
	end

	// ****************************************
	// Data write-back and discard
	// ****************************************
	// Write lands one clock after the read; the address is still held then
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dm_we_reg <= 1'b0;
			dm_wdata_reg <= '0;
		end else begin
			dm_we_reg <= in_exec &&
				(op_reg.code == bcbt_pkg::OP_SET_REGISTER_BIT);
			if (in_exec) begin
				dm_wdata_reg <= set_val;
			end
		end
	end

	// Second cycle runs a no-operation in place of the fetched word
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			discard_reg <= 1'b0;
		end else begin
			discard_reg <= in_exec && two_cycle;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign op_ready_o = (state_reg == bcbt_pkg::ST_IDLE);
	assign op_done_o = (in_exec && !two_cycle) ||
		(state_reg == bcbt_pkg::ST_FINISH);
	assign pc_o = pc_reg;
	assign dm_addr_o = op_reg.faddr;
	assign dm_we_o = dm_we_reg;
	assign dm_wdata_o = dm_wdata_reg;
	assign return_stack_top_push_o = push_reg;
	assign return_stack_top_o = push_data_reg;
	assign discard_next_o = discard_reg;
	// None of these operations touch a status flag
	assign status_we_o = 1'b0;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_start(bcbt_pkg::bcbt_op_t c);
		in_exec && op_reg.code == c;
	endsequence

	sequence s_two_cycle;
		!op_ready_o && !op_done_o ##1 !op_ready_o && op_done_o ##1
			op_ready_o;
	endsequence

	a_lit_target: assert property (s_start(
		bcbt_pkg::OP_BRANCH_RELATIVE_LITERAL) |=> pc_o == `BCBT_PC_W'(
		$past(pc_o) + `BCBT_PC_STEP + `BCBT_PC_W'(signed'(
		$past(op_reg.literal)))))
		else $error("literal branch target wrong");

	a_lit_timing: assert property (s_start(
		bcbt_pkg::OP_BRANCH_RELATIVE_LITERAL) |-> s_two_cycle and
		!status_we_o[*2])
		else $error("literal branch timing wrong");

	a_acc_target: assert property (s_start(
		bcbt_pkg::OP_BRANCH_RELATIVE_ACCUMULATOR) |=> pc_o ==
		`BCBT_PC_W'($past(pc_o) + `BCBT_PC_STEP +
		`BCBT_PC_W'($past(accum_reg))))
		else $error("accumulator branch target wrong");

	a_acc_timing: assert property (s_start(
		bcbt_pkg::OP_BRANCH_RELATIVE_ACCUMULATOR) |-> s_two_cycle and
		!status_we_o[*2])
		else $error("accumulator branch timing wrong");

	a_set_bit: assert property (s_start(bcbt_pkg::OP_SET_REGISTER_BIT)
		|=> dm_we_o && dm_wdata_o == ($past(dm_rdata_i) |
		(`BCBT_DATA_W'(1) << $past(op_reg.bitsel))) && !discard_next_o)
		else $error("set bit write wrong");

	a_skip_clear: assert property (s_start(bcbt_pkg::OP_TEST_SKIP_IF_CLEAR)
		|=> discard_next_o == !$past(bit_val) && pc_o == ($past(bit_val) ?
		$past(pc_o) + `BCBT_PC_STEP : $past(pc_o) + `BCBT_PC_SKIP))
		else $error("skip if clear wrong");

	a_skip_set: assert property (s_start(bcbt_pkg::OP_TEST_SKIP_IF_SET)
		|=> discard_next_o == $past(bit_val) && pc_o == ($past(bit_val) ?
		$past(pc_o) + `BCBT_PC_SKIP : $past(pc_o) + `BCBT_PC_STEP))
		else $error("skip if set wrong");

	a_call_push: assert property (s_start(bcbt_pkg::OP_CALL_ABSOLUTE)
		|=> return_stack_top_push_o && return_stack_top_o ==
		$past(pc_o) + `BCBT_PC_STEP)
		else $error("call return address wrong");

	a_call_load: assert property (s_start(bcbt_pkg::OP_CALL_ABSOLUTE)
		|=> pc_o == {$past(latch_reg[`BCBT_LATCH_HI:`BCBT_LATCH_LO]),
		$past(op_reg.target)})
		else $error("call target wrong");

	a_call_timing: assert property (s_start(bcbt_pkg::OP_CALL_ABSOLUTE)
		|-> s_two_cycle and !status_we_o[*2])
		else $error("call timing wrong");

	a_branch_wrap: assert property (in_exec && op_reg.code ==
		bcbt_pkg::OP_BRANCH_RELATIVE_ACCUMULATOR && pc_o == `BCBT_PC_MAX
		|=> pc_o == `BCBT_PC_W'($past(accum_reg)))
		else $error("branch target does not wrap");

endmodule
`default_nettype wire

// [bcbt_partner_model.sv]
// Partner model: data memory and return stack beside the execution block.
// Assumes reads are answered combinationally and writes land on mclk_i.
`timescale 1ns/1ns
`default_nettype none
`include "bcbt_regs.svh"

module bcbt_partner_model (
	input wire logic mclk_i,
	input wire logic [`BCBT_FADDR_W-1:0] dm_addr_i,
	input wire logic dm_we_i,
	input wire logic [`BCBT_DATA_W-1:0] dm_wdata_i,
	input wire logic push_i,
	input wire logic [`BCBT_PC_W-1:0] top_i,
	output logic [`BCBT_DATA_W-1:0] dm_rdata_o
);
	// Data bytes, preset with a pattern that the bench mirrors
	logic [`BCBT_DATA_W-1:0] mem [0:127];
	// Pushed return addresses; wraps at 16, overflow is not modelled
	logic [`BCBT_PC_W-1:0] stack [0:15];
	logic [3:0] depth_reg;

	// Preset contents so tested bits come out both ways
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i * 37 + 90);
		end
		depth_reg = 4'h0;
	end

	// Read answers at once, as the block expects
	assign dm_rdata_o = mem[dm_addr_i];

	// Writes and pushes take effect on the rising edge
	always @(posedge mclk_i) begin
		if (dm_we_i) begin
			mem[dm_addr_i] <= dm_wdata_i;
		end
		if (push_i) begin
			stack[depth_reg] <= top_i;
			depth_reg <= depth_reg + 4'h1;
		end
	end
endmodule
`default_nettype wire

// [branch_call_bit_test_exec_tb.sv]
// Self-checking bench for the branch, call and bit-test execution block.
// Assumes bcbt_pkg is compiled first and the partner model is present.
`timescale 1ns/1ns
`default_nettype none
`include "bcbt_regs.svh"

`define CHECK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("mismatch %0t got %0h exp %0h", $time, got, exp); \
	end \
end

module branch_call_bit_test_exec_tb;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic op_valid_i = 1'b0;
	bcbt_pkg::bcbt_req_t op_i = '0;
	logic [7:0] accum_i = 8'h00;
	logic [6:0] pc_upper_latch_i = 7'h00;
	logic [7:0] dm_rdata_i;
	logic op_ready_o, op_done_o, dm_we_o, status_we_o;
	logic return_stack_top_push_o, discard_next_o;
	logic [14:0] pc_o, return_stack_top_o;
	logic [6:0] dm_addr_o;
	logic [7:0] dm_wdata_o;
	int mismatches = 0;
	int num_checks = 0;
	integer seed = 32'hf595;
	logic [7:0] shadow [0:127];
	logic [14:0] exp_pc = 15'h0000;

	// 125 MHz clock
	always #4 mclk_i = ~mclk_i;

	bcbt_exec bcbt_exec_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.op_valid_i(op_valid_i), .op_i(op_i), .accum_i(accum_i),
		.pc_upper_latch_i(pc_upper_latch_i), .dm_rdata_i(dm_rdata_i),
		.op_ready_o(op_ready_o), .op_done_o(op_done_o), .pc_o(pc_o),
		.dm_addr_o(dm_addr_o), .dm_we_o(dm_we_o), .dm_wdata_o(dm_wdata_o),
		.return_stack_top_push_o(return_stack_top_push_o),
		.return_stack_top_o(return_stack_top_o),
		.discard_next_o(discard_next_o), .status_we_o(status_we_o));

	bcbt_partner_model bcbt_partner_model_i (.mclk_i(mclk_i),
		.dm_addr_i(dm_addr_o), .dm_we_i(dm_we_o), .dm_wdata_i(dm_wdata_o),
		.push_i(return_stack_top_push_o), .top_i(return_stack_top_o),
		.dm_rdata_o(dm_rdata_i));

	// ****************************************
	// Expectations
	// ****************************************
	// Next counter value; sums wrap at 15 bits on purpose
	function automatic logic [14:0] next_pc(logic [2:0] c, logic [14:0] pc,
		logic [8:0] l, logic [10:0] t, logic [7:0] a, logic [6:0] lt,
		logic b);
		case (c)
			3'h0: return pc + 15'h1 + {{6{l[8]}}, l};
			3'h1: return pc + 15'h1 + {7'h00, a};
			3'h3: return pc + (b ? 15'h1 : 15'h2);
			3'h4: return pc + (b ? 15'h2 : 15'h1);
			3'h5: return {lt[6:3], t};
			default: return pc + 15'h1;
		endcase
	endfunction

	function automatic bcbt_pkg::bcbt_req_t mk(logic [2:0] c, logic [8:0] l,
		logic [10:0] t, logic [6:0] f, logic [2:0] s);
		bcbt_pkg::bcbt_req_t r;
		r.code = bcbt_pkg::bcbt_op_t'(c);
		r.literal = l;
		r.target = t;
		r.faddr = f;
		r.bitsel = s;
		return r;
	endfunction

	// ****************************************
	// Closing report
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One instruction: offer when idle, then watch every cycle to done
	task automatic run_op(bcbt_pkg::bcbt_req_t r, logic [7:0] a,
		logic [6:0] lt);
		int cyc;
		logic b, long_op, got_done;
		logic [2:0] c;
		logic [7:0] old;
		int pushes, discards;
		logic [14:0] ret;
		logic [14:0] pushed;
		c = r.code;
		old = shadow[r.faddr];
		b = old[r.bitsel];
		long_op = c < 3'h2 || c == 3'h5 || (c == 3'h3 && !b) ||
			(c == 3'h4 && b);
		cyc = 0;
		@(negedge mclk_i);
		while (op_ready_o !== 1'b1 && cyc < 20) begin
			@(negedge mclk_i);
			cyc++;
		end
		// A block that never returns to idle ends the run as a failure
		if (op_ready_o !== 1'b1) begin
			mismatches++;
			print_verdict();
		end
		@(posedge mclk_i);
		op_valid_i <= 1'b1;
		op_i <= r;
		accum_i <= a;
		pc_upper_latch_i <= lt;
		// Accept edge; then scramble inputs so late sampling shows up
		@(posedge mclk_i);
		op_valid_i <= 1'b0;
		op_i <= ~r;
		accum_i <= ~a;
		pc_upper_latch_i <= ~lt;
		got_done = 1'b0;
		pushes = 0;
		discards = 0;
		for (cyc = 0; cyc < 4 && !got_done; cyc++) begin
			@(negedge mclk_i);
			`CHECK(status_we_o, 1'b0)
			if (return_stack_top_push_o === 1'b1) begin
				pushes++;
				`CHECK(return_stack_top_o, exp_pc + 15'h1)
			end
			if (discard_next_o === 1'b1) begin
				discards++;
			end
			got_done = (op_done_o === 1'b1);
		end
		if (!got_done) begin
			mismatches++;
			print_verdict();
		end
		`CHECK(cyc, long_op ? 2 : 1)
		`CHECK(discards, (long_op ? 1 : 0))
		`CHECK(pushes, (c == 3'h5 ? 1 : 0))
		ret = exp_pc + 15'h1;
		exp_pc = next_pc(c, exp_pc, r.literal, r.target, a, lt, b);
		// Results settle by the cycle after done
		@(negedge mclk_i);
		`CHECK(pc_o, exp_pc)
		`CHECK(dm_we_o, (c == 3'h2))
		if (c == 3'h2) begin
			shadow[r.faddr] = old | (8'h01 << r.bitsel);
			`CHECK(dm_addr_o, r.faddr)
			`CHECK(dm_wdata_o, shadow[r.faddr])
		end
		// The pushed address must have landed on the model's stack
		if (c == 3'h5) begin
			pushed = bcbt_partner_model_i.stack[
				bcbt_partner_model_i.depth_reg - 4'h1];
			`CHECK(pushed, ret)
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		for (int i = 0; i < 128; i++) begin
			shadow[i] = 8'(i * 37 + 90);
		end
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		@(negedge mclk_i);
		`CHECK(pc_o, 15'h0000)
		`CHECK(op_ready_o, 1'b1)
		// Offset extremes, wrap below zero, widest accumulator, call corners
		run_op(mk(3'h0, 9'h100, 11'h0, 7'h0, 3'h0), 8'h00, 7'h00);
		run_op(mk(3'h0, 9'h0ff, 11'h0, 7'h0, 3'h0), 8'h00, 7'h00);
		run_op(mk(3'h1, 9'h000, 11'h0, 7'h0, 3'h0), 8'hff, 7'h00);
		run_op(mk(3'h5, 9'h000, 11'h7ff, 7'h0, 3'h0), 8'h00, 7'h7f);
		// Counter now at the top of the space: accumulator branch wraps
		run_op(mk(3'h1, 9'h000, 11'h0, 7'h0, 3'h0), 8'h05, 7'h00);
		run_op(mk(3'h5, 9'h000, 11'h7ff, 7'h0, 3'h0), 8'h00, 7'h7f);
		run_op(mk(3'h5, 9'h000, 11'h000, 7'h0, 3'h0), 8'h00, 7'h07);
		run_op(mk(3'h2, 9'h000, 11'h0, 7'h7f, 3'h7), 8'h00, 7'h00);
		// Both tests on every bit of one byte, then the spare codes
		for (int i = 0; i < 16; i++) begin
			run_op(mk(3'(3 + i / 8), 9'h0, 11'h0, 7'h7f, 3'(i)), 8'h0, 7'h0);
		end
		run_op(mk(3'h6, 9'h000, 11'h0, 7'h0, 3'h0), 8'h00, 7'h00);
		run_op(mk(3'h7, 9'h000, 11'h0, 7'h0, 3'h0), 8'h00, 7'h00);
		$display("test corner cases done");
		// Reset in mid-run: counter and strobes return to rest
		@(posedge mclk_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		`CHECK(pc_o, 15'h0000)
		`CHECK(op_ready_o, 1'b1)
		`CHECK(op_done_o, 1'b0)
		`CHECK(dm_we_o, 1'b0)
		`CHECK(discard_next_o, 1'b0)
		`CHECK(return_stack_top_push_o, 1'b0)
		@(posedge mclk_i);
		arst_n_i <= 1'b1;
		exp_pc = 15'h0000;
		@(negedge mclk_i);
		`CHECK(pc_o, 15'h0000)
		`CHECK(op_ready_o, 1'b1)
		$display("test mid-run reset done");
		for (int i = 0; i < 400; i++) begin
			run_op(mk(3'($random(seed)), 9'($random(seed)),
				11'($random(seed)), 7'($random(seed)), 3'($random(seed))),
				8'($random(seed)), 7'($random(seed)));
		end
		$display("test random operations done");
		print_verdict();
	end
endmodule
`default_nettype wire
